// [inc/osc_pkg.sv]
// constants, carriers and state types of the oscillator switch control block
package osc_pkg;
  // register byte addresses
  localparam logic [7:0] OSC_ADR_CTRL = 8'h00;
  localparam logic [7:0] OSC_ADR_KEY  = 8'h04;
  localparam logic [7:0] OSC_ADR_STAT = 8'h08;
  localparam logic [7:0] OSC_ADR_CLR  = 8'h0C;
  localparam logic [7:0] OSC_ADR_EN   = 8'h10;
  // oscillator_control field positions
  localparam int OSC_BIT_SWREQ = 0;
  localparam int OSC_BIT_FAIL  = 3;
  localparam int OSC_NSRC_LSB  = 8;
  localparam int OSC_CSRC_LSB  = 12;
  localparam int OSC_SRC_W     = 3;
  // unlock key bytes, values arbitrary
  localparam logic [7:0] OSC_KEY1 = 8'hA5;
  localparam logic [7:0] OSC_KEY2 = 8'h5A;
  // interrupt status layout
  localparam int OSC_IRQ_FAIL = 0;
  localparam int OSC_IRQ_DONE = 1;
  localparam int OSC_IRQ_W    = 2;
  // reset values
  localparam logic [2:0] OSC_RST_SRC = 3'h0;
  localparam logic [1:0] OSC_RST_EN  = 2'h0;
  localparam logic [1:0] OSC_RST_STAT = 2'h0;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } osc_wb_req_t;

  // switch engine progress
  typedef enum logic [1:0] {
    OSC_SW_IDLE,
    OSC_SW_WAIT,
    OSC_SW_DRAIN
  } osc_sw_state_t;

  // unlock sequence progress
  typedef enum logic [1:0] {
    OSC_LK_LOCKED,
    OSC_LK_HALF,
    OSC_LK_OPEN
  } osc_lk_state_t;
endpackage : osc_pkg

// [verilog/osc_switch_ctrl.sv]
// oscillator switch control: fail flag, forced trap, switch handshake, unlock
`timescale 1ns/10ps
module osc_switch_ctrl
  import osc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire osc_wb_req_t wb_req,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack,
  input  wire logic        fail_detect,
  input  wire logic        source_ready,
  output logic             switch_req,
  output logic [2:0]       active_source,
  output logic             fail_trap,
  output logic             irq
);

  // synchronisers for the two asynchronous oscillator inputs
  logic fail_s1;
  logic fail_s2;
  logic fail_s3;
  logic rdy_s1;
  logic rdy_s2;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fail_s1 <= 1'b0;
      fail_s2 <= 1'b0;
      fail_s3 <= 1'b0;
      rdy_s1  <= 1'b0;
      rdy_s2  <= 1'b0;
    end else begin
      fail_s1 <= fail_detect;
      fail_s2 <= fail_s1;
      fail_s3 <= fail_s2;
      rdy_s1  <= source_ready;
      rdy_s2  <= rdy_s1;
    end
  end

  // state
  logic                 fail_flag;
  logic                 sw_bit;
  logic [2:0]           nsrc;
  logic [2:0]           target;
  osc_sw_state_t        sw_state;
  osc_lk_state_t        lk_state;
  logic [OSC_IRQ_W-1:0] irq_stat;
  logic [OSC_IRQ_W-1:0] irq_en;

  // bus decode
  wire bus_req  = wb_req.cyc & wb_req.stb & ~wb_ack;
  wire bus_wr   = bus_req & wb_req.we;
  wire bus_rd   = bus_req & ~wb_req.we;
  wire hit_ctrl = wb_req.adr == OSC_ADR_CTRL;
  wire hit_key  = wb_req.adr == OSC_ADR_KEY;
  wire hit_stat = wb_req.adr == OSC_ADR_STAT;
  wire hit_clr  = wb_req.adr == OSC_ADR_CLR;
  wire hit_en   = wb_req.adr == OSC_ADR_EN;
  wire wr_ctrl  = bus_wr & hit_ctrl;
  wire wr_key   = bus_wr & hit_key & wb_req.sel[0];
  wire wr_clr   = bus_wr & hit_clr & wb_req.sel[0];
  wire wr_en    = bus_wr & hit_en & wb_req.sel[0];
  wire [7:0] key_byte = wb_req.dat[7:0];

  // a control write lands only straight after a full unlock
  wire unlocked = lk_state == OSC_LK_OPEN;
  wire ctrl_lo  = wr_ctrl & unlocked & wb_req.sel[0];
  wire ctrl_hi  = wr_ctrl & unlocked & wb_req.sel[1];
  wire sw_idle  = sw_state == OSC_SW_IDLE;
  wire [2:0] wr_nsrc = wb_req.dat[OSC_NSRC_LSB +: OSC_SRC_W];

  // unlock sequencer; any other write throws away the unlock
  osc_lk_state_t next_lk;
  always_comb begin
    next_lk = lk_state;
    if (bus_wr) begin
      if (wr_key && key_byte == OSC_KEY1) begin
        next_lk = OSC_LK_HALF;
      end else if (wr_key && key_byte == OSC_KEY2 && lk_state == OSC_LK_HALF) begin
        next_lk = OSC_LK_OPEN;
      end else begin
        next_lk = OSC_LK_LOCKED;
      end
    end
  end

  // failure flag: monitor edge or software one sets, software zero clears
  wire hw_fail  = fail_s2 & ~fail_s3;
  wire sw_fail  = ctrl_lo & wb_req.dat[OSC_BIT_FAIL];
  wire sw_clear = ctrl_lo & ~wb_req.dat[OSC_BIT_FAIL];
  wire fail_set = hw_fail | sw_fail;
  // set beats clear so a failure in the clearing cycle is kept
  wire next_fail = fail_set | (fail_flag & ~sw_clear);

  // switch request start: only from idle, new source taken with it
  wire [2:0] next_nsrc = (ctrl_hi && sw_idle) ? wr_nsrc : nsrc;
  wire sw_start = ctrl_lo & wb_req.dat[OSC_BIT_SWREQ] & sw_idle;
  wire sw_done  = (sw_state == OSC_SW_WAIT) & rdy_s2;

  // switch engine: request out, wait for new source, wait for ready to drop
  osc_sw_state_t next_sw;
  always_comb begin
    next_sw = sw_state;
    case (sw_state)
      OSC_SW_IDLE: begin
        if (sw_start) begin
          next_sw = OSC_SW_WAIT;
        end
      end
      OSC_SW_WAIT: begin
        if (rdy_s2) begin
          next_sw = OSC_SW_DRAIN;
        end
      end
      OSC_SW_DRAIN: begin
        if (!rdy_s2) begin
          next_sw = OSC_SW_IDLE;
        end
      end
      default: begin
        next_sw = OSC_SW_IDLE;
      end
    endcase
  end

  // interrupt status: sticky events, write-one clear, set wins
  wire [OSC_IRQ_W-1:0] irq_evt = {sw_done, fail_set};
  wire [OSC_IRQ_W-1:0] irq_clr = wr_clr ? wb_req.dat[OSC_IRQ_W-1:0] : '0;
  wire [OSC_IRQ_W-1:0] next_stat = irq_evt | (irq_stat & ~irq_clr);
  wire [OSC_IRQ_W-1:0] next_en = wr_en ? wb_req.dat[OSC_IRQ_W-1:0] : irq_en;

  // read word of oscillator_control; unimplemented bits stay zero
  wire [31:0] ctrl_word = {17'h0, active_source, 1'h0, nsrc, 4'h0,
                           fail_flag, 2'h0, sw_bit};
  wire [31:0] rd_word =
      hit_ctrl ? ctrl_word :
      hit_key  ? {31'h0, unlocked} :
      hit_stat ? {{(32-OSC_IRQ_W){1'b0}}, irq_stat} :
      hit_en   ? {{(32-OSC_IRQ_W){1'b0}}, irq_en} :
      32'h0; // unmapped and clear register read zero

  // bus answer: ack one cycle after the strobe, then dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack   <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack   <= bus_req;
      wb_dat_o <= bus_rd ? rd_word : 32'h0;
    end
  end

  // control fields and unlock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lk_state  <= OSC_LK_LOCKED;
      fail_flag <= 1'b0;
      nsrc      <= OSC_RST_SRC;
      fail_trap <= 1'b0;
    end else begin
      lk_state  <= next_lk;
      fail_flag <= next_fail;
      nsrc      <= next_nsrc;
      fail_trap <= fail_set;
    end
  end

  // switch engine registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sw_state      <= OSC_SW_IDLE;
      sw_bit        <= 1'b0;
      switch_req    <= 1'b0;
      target        <= OSC_RST_SRC;
      active_source <= OSC_RST_SRC;
    end else begin
      sw_state <= next_sw;
      if (sw_start) begin
        sw_bit     <= 1'b1;
        switch_req <= 1'b1;
        target     <= next_nsrc;
      end else if (sw_done) begin
        sw_bit        <= 1'b0;
        switch_req    <= 1'b0;
        active_source <= target;
      end
    end
  end

  // interrupt registers; irq lags status by one cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= OSC_RST_STAT;
      irq_en   <= OSC_RST_EN;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      irq_en   <= next_en;
      irq      <= |(irq_stat & irq_en);
    end
  end

  // source pairs that must go through plain fast rc are not policed here;
  // the oscillator side relies on software for that

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence sw_req_s;
    sw_start;
  endsequence

  sequence sw_wait_s;
    switch_req && sw_bit && sw_state == OSC_SW_WAIT;
  endsequence

  sequence sw_fin_s;
    sw_state == OSC_SW_WAIT && rdy_s2;
  endsequence

  property p_switch_start;
    sw_req_s |=> sw_wait_s;
  endproperty

  property p_switch_done;
    sw_fin_s |=> !sw_bit && !switch_req && active_source == $past(target);
  endproperty

  a_ack_single: assert property (wb_ack |=> !wb_ack)
    else $error("ack held longer than one cycle");

  a_ack_follows: assert property (bus_req |=> wb_ack)
    else $error("request not answered next cycle");

  a_hw_fail_set: assert property (hw_fail |=> fail_flag && fail_trap)
    else $error("monitor failure did not set flag");

  a_sw_fail_trap: assert property (sw_fail |=> fail_trap && fail_flag)
    else $error("software set of flag raised no trap");

  a_trap_cause: assert property (fail_trap |-> $past(fail_set))
    else $error("trap without a failure cause");

  a_switch_start: assert property (p_switch_start)
    else $error("switch request not taken");

  a_switch_hold: assert property (sw_bit && !rdy_s2 |=> sw_bit)
    else $error("switch bit dropped before completion");

  a_switch_done: assert property (p_switch_done)
    else $error("switch completion not reflected");

  a_unlock_open: assert property (
    wr_key && key_byte == OSC_KEY2 && lk_state == OSC_LK_HALF |=> unlocked)
    else $error("unlock sequence did not open writes");

  a_locked_ignore: assert property (
    wr_ctrl && !unlocked |=> $stable(nsrc) && !$rose(sw_bit))
    else $error("locked write changed the control register");

  a_relock_write: assert property (bus_wr && !wr_key |=> !unlocked)
    else $error("unlock survived another write");

  a_reserved_zero: assert property (
    bus_rd && hit_ctrl |=> wb_dat_o[4] == 1'b0 && wb_dat_o[2:1] == 2'h0)
    else $error("unimplemented control bits read nonzero");

  a_irq_level: assert property (|(irq_stat & irq_en) |=> irq)
    else $error("enabled status did not raise irq");

endmodule : osc_switch_ctrl

// [verification/osc_src_model.sv]
// oscillator source model answering switch requests after a chosen delay
`timescale 1ns/10ps
module osc_src_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [3:0] delay,
  input  wire logic       switch_req,
  output logic            source_ready
);
  logic [3:0] cnt;

  // ready only after the set delay, so slow sources are exercised too
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt          <= 4'h0;
      source_ready <= 1'b0;
    end else if (!switch_req) begin
      cnt          <= 4'h0;
      source_ready <= 1'b0;
    end else if (cnt == delay) begin
      source_ready <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : osc_src_model

// [verification/osc_switch_ctrl_tb.sv]
// self-checking bench of the oscillator switch control block
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module osc_switch_ctrl_tb
  import osc_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        fail_detect = 1'b0;
  osc_wb_req_t wb_req = '0;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack, source_ready, switch_req, fail_trap, irq;
  logic [2:0]  active_source, nsrc, act;
  logic [3:0]  delay = 4'h6;
  int          fail_count = 0, comparisons = 0, traps = 0, n;
  // source code taken as plain fast rc, the stop between the two pll modes
  localparam logic [2:0] SRC_PLAIN_RC = 3'h0;

  osc_switch_ctrl u_dut (.clk(clk), .nrst(nrst), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack(wb_ack), .fail_detect(fail_detect), .source_ready(source_ready),
    .switch_req(switch_req), .active_source(active_source), .fail_trap(fail_trap), .irq(irq));
  osc_src_model u_src (.clk(clk), .nrst(nrst), .delay(delay), .switch_req(switch_req),
    .source_ready(source_ready));

  always #10 clk = ~clk;
  // trap pulses are one cycle long, so count them rather than poll
  always @(posedge clk) if (fail_trap === 1'b1) traps <= traps + 1;

  function automatic logic [31:0] ctrl_exp(input logic [2:0] ns, cs, input logic fl, sw);
    ctrl_exp = {17'h0, cs, 1'b0, ns, 4'h0, fl, 2'b00, sw};
  endfunction : ctrl_exp

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, w, a, 4'h3, d};
    k = 0;
    // ack and data are read at the rising edge that samples them, before they move
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      end_of_test;
    end
    rd = wb_dat_o;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
  endtask : bus

  task automatic unlock;
    bus(1'b1, OSC_ADR_KEY, {24'h0, OSC_KEY1});
    bus(1'b1, OSC_ADR_KEY, {24'h0, OSC_KEY2});
  endtask : unlock

  task automatic end_of_test;
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_of_test;
  end

  initial begin
    void'($urandom(32'h9483183E));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, OSC_ADR_CTRL, 32'h0);
    `CHK(rd, ctrl_exp(3'h0, 3'h0, 1'b0, 1'b0))
    // locked write, then an unlock spoiled by a stray write
    bus(1'b1, OSC_ADR_CTRL, 32'h0000_071F);
    unlock;
    bus(1'b1, OSC_ADR_EN, 32'h3);
    bus(1'b1, OSC_ADR_CTRL, 32'h0000_0708);
    bus(1'b0, OSC_ADR_CTRL, 32'h0);
    `CHK(rd, ctrl_exp(3'h0, 3'h0, 1'b0, 1'b0))
    `CHK(traps, 0)
    act = 3'h0;
    for (int i = 0; i < 4; i++) begin
      // every other switch goes back to plain fast rc, so pll modes never meet
      nsrc = (i % 2 == 1) ? SRC_PLAIN_RC : 3'($urandom_range(7, 1));
      delay <= 4'($urandom_range(15, 6));
      unlock;
      bus(1'b1, OSC_ADR_CTRL, {21'h0, nsrc, 8'h17});
      bus(1'b0, OSC_ADR_CTRL, 32'h0);
      `CHK(rd, ctrl_exp(nsrc, act, 1'b0, 1'b1))
      `CHK(switch_req, 1'b1)
      n = 0;
      while (switch_req === 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      if (n >= 100) begin
        fail_count++;
        end_of_test;
      end
      act = nsrc;
      bus(1'b0, OSC_ADR_CTRL, 32'h0);
      `CHK(rd, ctrl_exp(nsrc, act, 1'b0, 1'b0))
      `CHK(active_source, act)
    end
    // switch done event raised, then cleared
    `CHK(irq, 1'b1)
    bus(1'b1, OSC_ADR_CLR, 32'h2);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    // forced failure through software, then cleared again
    unlock;
    bus(1'b1, OSC_ADR_CTRL, {21'h0, act, 8'h08});
    bus(1'b0, OSC_ADR_CTRL, 32'h0);
    `CHK(rd, ctrl_exp(act, act, 1'b1, 1'b0))
    `CHK(traps, 1)
    `CHK(irq, 1'b1)
    unlock;
    bus(1'b1, OSC_ADR_CTRL, {21'h0, act, 8'h00});
    bus(1'b1, OSC_ADR_EN, 32'h0);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    // monitor failure
    fail_detect <= 1'b1;
    repeat (8) @(posedge clk);
    fail_detect <= 1'b0;
    bus(1'b0, OSC_ADR_CTRL, 32'h0);
    `CHK(rd, ctrl_exp(act, act, 1'b1, 1'b0))
    `CHK(traps, 2)
    bus(1'b0, OSC_ADR_STAT, 32'h0);
    `CHK(rd, 32'h0000_0001)
    bus(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    end_of_test;
  end
endmodule : osc_switch_ctrl_tb
